// ===== pkg/sfplc_regs.vh
// Constants of the transceiver laser control and status block.
// Assumes it is included by bare name from the design files.
`ifndef SFPLC_REGS_VH
`define SFPLC_REGS_VH

// Two-wire device address of the diagnostic space (0xa2 as 8-bit form)
`define SFPLC_DEV_ADDR 7'h51
`define SFPLC_ADDR_W 8

// Status/control byte offset in the diagnostic space
`define SFPLC_REG_STATUS 8'h6e

// Field positions in the status/control byte
`define SFPLC_BIT_DIS_STATE 7
`define SFPLC_BIT_SOFT_DIS 6
`define SFPLC_BIT_FAULT 2
`define SFPLC_BIT_LOS 1

// Reset values and the read value of unmapped bytes
`define SFPLC_SOFT_DIS_RST 1'h0
`define SFPLC_PTR_RST 8'h00
`define SFPLC_UNMAPPED_BYTE 8'h00

// Bit counter figures of one serial byte
`define SFPLC_BITS_PER_BYTE 4'h8
`define SFPLC_BITCNT_ZERO 4'h0
`define SFPLC_BITCNT_ONE 4'h1

`endif

// ===== tb/sfp_laser_control_status_bench.sv
// Self-checking bench of the laser control and status block.
// Assumes the host model and the checker are compiled alongside.
module sfp_laser_control_status_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, off_req, fdet, eye, slow, rxlow, ok, ack;
   logic [7:0] rd;
   wire scl, sda_rel, sda_o, sda_oe_n, flag, lon, txr, los;
   int mismatches, compares, cyc;
   // Open-drain data wire with pull-up
   wire sda = sda_rel & (sda_oe_n | sda_o);
   sfplc_top sfplc_top_inst (.i_clk(clk), .i_rst_n(rst_n),
      .i_laser_off_request(off_req), .i_laser_fault_det(fdet),
      .i_eye_safety_trip(eye), .i_supply_low(slow), .i_rx_power_low(rxlow),
      .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n),
      .o_laser_fault_flag(flag), .o_laser_on(lon), .o_tx_reset(txr),
      .o_optical_signal_lost(los));
   sfplc_host_model sfplc_host_model_inst (.i_clk(clk), .i_sda(sda),
      .o_scl(scl), .o_sda_rel(sda_rel));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task rd_at(input logic [7:0] a, input logic [7:0] exp);
      sfplc_host_model_inst.reg_read(a, rd, ok);
      chk(8'(ok), 8'h01);
      chk(rd, exp);
   endtask
   task wr_at(input logic [7:0] a, input logic [7:0] d);
      sfplc_host_model_inst.reg_write(a, d, ok);
      chk(8'(ok), 8'h01);
   endtask
   task t_pin();
      off_req = 1'b1;
      tick(2);
      chk(8'(lon), 8'h00);
      rd_at(8'h6e, 8'h80);
      off_req = 1'b0;
      tick(2);
      chk(8'(lon), 8'h01);
   endtask
   // Soft bit alone disables; only bit 6 takes a write
   task t_soft();
      wr_at(8'h6e, 8'h40);
      tick(2);
      chk(8'(lon), 8'h00);
      wr_at(8'h6e, 8'hff);
      rd_at(8'h6e, 8'h40);
      wr_at(8'h6e, 8'h00);
      tick(2);
      chk(8'(lon), 8'h01);
      wr_at(8'h10, 8'hff);
      rd_at(8'h10, 8'h00);
      sfplc_host_model_inst.probe(8'ha4, ack);
      chk(8'(ack), 8'h00);
   endtask
   // Laser fault, then eye trip: latch, refused clear, real clear
   task t_fault();
      for (int k = 0; k < 2; k++) begin
         fdet = (k == 0);
         eye = (k == 1);
         tick(1);
         fdet = 1'b0;
         eye = 1'b0;
         tick(3);
         chk(8'(flag), 8'h01);
         chk(8'(lon), 8'h00);
         rd_at(8'h6e, 8'h04);
         fdet = 1'b1;
         off_req = 1'b1;
         tick(1);
         off_req = 1'b0;
         fdet = 1'b0;
         tick(2);
         chk(8'(flag), 8'h01);
         off_req = 1'b1;
         tick(1);
         chk(8'(txr), 8'h01);
         chk(8'(flag), 8'h00);
         tick(1);
         chk(8'(txr), 8'h00);
         off_req = 1'b0;
         tick(2);
         chk(8'(lon), 8'h01);
      end
   endtask
   task t_supply();
      slow = 1'b1;
      tick(2);
      chk(8'(flag), 8'h01);
      chk(8'(lon), 8'h00);
      slow = 1'b0;
      tick(2);
      chk(8'(flag), 8'h00);
   endtask
   task t_los();
      rxlow = 1'b1;
      tick(2);
      chk(8'(los), 8'h01);
      rd_at(8'h6e, 8'h02);
      rxlow = 1'b0;
      tick(2);
      chk(8'(los), 8'h00);
      rd_at(8'h6e, 8'h00);
   endtask
   task tally_and_finish();
      if (mismatches == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs about 3500 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         $display("BAD %0t timeout", $time);
         tally_and_finish();
      end
   end
   initial begin
      {rst_n, off_req, fdet, eye, slow, rxlow} = 6'h00;
      tick(5);
      rst_n = 1'b1;
      tick(2);
      t_pin();
      t_soft();
      t_fault();
      t_supply();
      t_los();
      tally_and_finish();
   end
endmodule // sfp_laser_control_status_bench

// ===== tb/sfplc_host_model.sv
// Host side model: two-wire master on the diagnostic byte space.
// Assumes the bench resolves the data wire with a pull-up.
module sfplc_host_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_rel
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus: both wires released
   initial begin
      o_scl = 1'b1;
      o_sda_rel = 1'b1;
   end
   // Four cycles a phase keeps clear of the three-cycle minimum
   task ph();
      repeat (4) @(negedge i_clk);
   endtask
   task start();
      o_sda_rel = 1'b1;
      ph();
      o_scl = 1'b1;
      ph();
      o_sda_rel = 1'b0;
      ph();
      o_scl = 1'b0;
      ph();
   endtask
   task stop();
      o_sda_rel = 1'b0;
      ph();
      o_scl = 1'b1;
      ph();
      o_sda_rel = 1'b1;
      ph();
   endtask
   task bit_out(input logic b);
      o_sda_rel = b;
      ph();
      o_scl = 1'b1;
      ph();
      o_scl = 1'b0;
   endtask
   // Sample mid high phase, where the device output has settled
   task bit_in(output logic b);
      o_sda_rel = 1'b1;
      ph();
      o_scl = 1'b1;
      repeat (2) @(negedge i_clk);
      b = i_sda;
      repeat (2) @(negedge i_clk);
      o_scl = 1'b0;
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = !b;
   endtask
   task probe(input logic [7:0] dev, output logic ack);
      start();
      wbyte(dev, ack);
      stop();
   endtask
   task reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      wbyte(8'ha2, k0);
      wbyte(a, k1);
      wbyte(d, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   // Pointer write, repeated start, one byte read, then NACK
   task reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      wbyte(8'ha2, k0);
      wbyte(a, k1);
      start();
      wbyte(8'ha3, k2);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(1'b1);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule // sfplc_host_model

// ===== tb/sfplc_top_props.sv
// Pin-level assertions on the laser control and status block.
// Assumes one clock domain and the bind at the foot of this file.
module sfplc_top_props (
   input wire i_clk, input wire i_rst_n, input wire i_laser_off_request,
   input wire i_laser_fault_det, input wire i_eye_safety_trip,
   input wire i_supply_low, input wire i_rx_power_low, input wire i_scl,
   input wire i_sda, input wire o_sda_o, input wire o_sda_oe_n,
   input wire o_laser_fault_flag, input wire o_laser_on,
   input wire o_tx_reset, input wire o_optical_signal_lost
);
   wire cause = i_laser_fault_det | i_eye_safety_trip;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_pin_forces_off: assert property (
      i_laser_off_request |=> !o_laser_on) else $error("laser on");
   a_on_needs_clear: assert property (
      o_laser_on |-> !$past(i_laser_off_request) && !o_laser_fault_flag)
      else $error("laser on with cause");
   a_fault_raises_flag: assert property (
      cause | i_supply_low |=> o_laser_fault_flag && !o_laser_on)
      else $error("fault not flagged");
   a_flag_idle_low: assert property (
      !(cause | i_supply_low | o_laser_fault_flag) |=> !o_laser_fault_flag)
      else $error("flag without cause");
   a_fault_stays_latched: assert property (
      cause ##1 !i_laser_off_request [*3] |=> o_laser_fault_flag)
      else $error("latch lost");
   a_supply_not_latched: assert property (
      (i_supply_low && !cause && !o_laser_fault_flag) ##1
      !(i_supply_low | cause) |=> !o_laser_fault_flag)
      else $error("supply flag latched");
   a_toggle_clears: assert property (
      $rose(i_laser_off_request) && !cause && !i_supply_low
      |=> !o_laser_fault_flag && o_tx_reset) else $error("no clear");
   a_reset_one_cycle: assert property (
      o_tx_reset |=> !o_tx_reset) else $error("reset pulse long");
   a_los_tracks: assert property (
      i_rx_power_low ##1 !i_rx_power_low
      |-> o_optical_signal_lost ##1 !o_optical_signal_lost)
      else $error("los wrong");
   a_sda_only_low: assert property (
      !o_sda_oe_n |-> !o_sda_o) else $error("data driven high");
   cover property (o_tx_reset);
   cover property ($fell(o_sda_oe_n));
   cover property (i_supply_low ##1 o_laser_fault_flag);
endmodule // sfplc_top_props

bind sfplc_top sfplc_top_props sfplc_top_props_inst (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_laser_off_request(i_laser_off_request),
   .i_laser_fault_det(i_laser_fault_det),
   .i_eye_safety_trip(i_eye_safety_trip), .i_supply_low(i_supply_low),
   .i_rx_power_low(i_rx_power_low), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_o(o_sda_o), .o_sda_oe_n(o_sda_oe_n),
   .o_laser_fault_flag(o_laser_fault_flag), .o_laser_on(o_laser_on),
   .o_tx_reset(o_tx_reset), .o_optical_signal_lost(o_optical_signal_lost));

// ===== verilog/sfplc_edge.v
// Registered sampler with rise and fall pulses for one input line.
// Assumes the input is synchronous to i_clk.
module sfplc_edge (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_line,
   output reg o_level,
   output wire o_rise,
   output wire o_fall
);

   // Previous level; reset high matches an idle pulled-up line
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_level <= 1'b1;
      end else begin
         o_level <= i_line;
      end
   end

   // Edges compare the live sample against last cycle
   assign o_rise = i_line & ~o_level;
   assign o_fall = ~i_line & o_level;

endmodule // sfplc_edge

// ===== verilog/sfplc_fault_ctl.v
// Transmitter disable combination and latched fault logic.
// Assumes fault detector inputs are synchronous levels from the laser driver.
module sfplc_fault_ctl (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_laser_off_request,
   input wire i_soft_disable,
   input wire i_laser_fault_det,
   input wire i_eye_safety_trip,
   input wire i_supply_low,
   output reg o_laser_fault_flag,
   output reg o_laser_on,
   output reg o_tx_reset
);

   reg off_req_d;
   reg fault_latched;
   wire toggle;
   wire laser_fault;
   wire next_flag;

   // Assertion of the request pin is the recovery toggle
   assign toggle = i_laser_off_request & ~off_req_d;
   assign laser_fault = i_laser_fault_det | i_eye_safety_trip;
   // Low supply joins unlatched so the flag follows it; a clean toggle
   // drops the latched part in the same cycle the latch clears
   assign next_flag = (fault_latched & ~(toggle & ~laser_fault))
      | laser_fault | i_supply_low;

   // Latch: a fault in the toggle cycle wins over the clear
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         off_req_d <= 1'b0;
         fault_latched <= 1'b0;
      end else begin
         off_req_d <= i_laser_off_request;
         if (laser_fault) begin
            fault_latched <= 1'b1;
         end else if (toggle) begin
            fault_latched <= 1'b0;
         end
      end
   end

   // Outputs; laser held off after reset until the first clean cycle
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_laser_fault_flag <= 1'b0;
         o_laser_on <= 1'b0;
         o_tx_reset <= 1'b0;
      end else begin
         o_laser_fault_flag <= next_flag;
         o_laser_on <= ~(i_laser_off_request | i_soft_disable
            | next_flag);
         o_tx_reset <= toggle;
      end
   end

endmodule // sfplc_fault_ctl

// ===== verilog/sfplc_top.v
// Laser control and status block of a pluggable optical transceiver,
// with the two-wire slave that reaches the diagnostic byte space.
// Assumes all pins are synchronous to i_clk and the two-wire clock is far
// slower than i_clk; open-drain wires are resolved outside.
`include "sfplc_regs.vh"

module sfplc_top (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_laser_off_request,
   input wire i_laser_fault_det,
   input wire i_eye_safety_trip,
   input wire i_supply_low,
   input wire i_rx_power_low,
   input wire i_scl,
   input wire i_sda,
   output reg o_sda_o,
   output reg o_sda_oe_n,
   output wire o_laser_fault_flag,
   output wire o_laser_on,
   output wire o_tx_reset,
   output reg o_optical_signal_lost
);

   // Slave protocol states
   localparam ST_IDLE = 4'h0;
   localparam ST_ADDR = 4'h1;
   localparam ST_ADDR_ACK = 4'h2;
   localparam ST_PTR = 4'h3;
   localparam ST_PTR_ACK = 4'h4;
   localparam ST_WDATA = 4'h5;
   localparam ST_WDATA_ACK = 4'h6;
   localparam ST_RDATA = 4'h7;
   localparam ST_RACK = 4'h8;

   reg [3:0] state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg [`SFPLC_ADDR_W-1:0] ptr;
   reg rw;
   reg master_ack;
   reg soft_disable;

   wire scl_level;
   wire scl_rise;
   wire scl_fall;
   wire sda_level;
   wire sda_rise;
   wire sda_fall;
   wire start_cond;
   wire stop_cond;
   wire byte_done;
   wire addr_match;
   wire [7:0] status_byte;
   wire [7:0] rd_byte;

   // Line samplers for the two-wire clock and data
   sfplc_edge u_scl (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_line(i_scl),
      .o_level(scl_level),
      .o_rise(scl_rise),
      .o_fall(scl_fall)
   );

   sfplc_edge u_sda (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_line(i_sda),
      .o_level(sda_level),
      .o_rise(sda_rise),
      .o_fall(sda_fall)
   );

   // Fault latch, disable combination and transmitter reset
   sfplc_fault_ctl u_fault (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_laser_off_request(i_laser_off_request),
      .i_soft_disable(soft_disable),
      .i_laser_fault_det(i_laser_fault_det),
      .i_eye_safety_trip(i_eye_safety_trip),
      .i_supply_low(i_supply_low),
      .o_laser_fault_flag(o_laser_fault_flag),
      .o_laser_on(o_laser_on),
      .o_tx_reset(o_tx_reset)
   );

   // Data moving while the clock stays high marks start and stop
   assign start_cond = sda_fall & scl_level & i_scl;
   assign stop_cond = sda_rise & scl_level & i_scl;
   assign byte_done = (bitcnt == `SFPLC_BITS_PER_BYTE);
   assign addr_match = (shreg[7:1] == `SFPLC_DEV_ADDR);

   // Status byte built from live levels so each read sees the present state
   assign status_byte = {
      i_laser_off_request,
      soft_disable,
      3'h0,
      o_laser_fault_flag,
      o_optical_signal_lost,
      1'h0
   };

   // Byte space read decode; bytes outside this block read as zero
   function [7:0] sfplc_read_byte;
      input [`SFPLC_ADDR_W-1:0] addr;
      input [7:0] status;
      begin
         if (addr == `SFPLC_REG_STATUS) begin
            sfplc_read_byte = status;
         end else begin
            sfplc_read_byte = `SFPLC_UNMAPPED_BYTE;
         end
      end
   endfunction

   assign rd_byte = sfplc_read_byte(ptr, status_byte);

   // Receiver loss of signal is passed through one flop
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_optical_signal_lost <= 1'b0;
      end else begin
         o_optical_signal_lost <= i_rx_power_low;
      end
   end

   // Two-wire slave: bits are sampled on clock rise, driven on clock fall.
   // Start and stop take priority so a confused master can always resync.
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         bitcnt <= `SFPLC_BITCNT_ZERO;
         shreg <= 8'h00;
         ptr <= `SFPLC_PTR_RST;
         rw <= 1'b0;
         master_ack <= 1'b0;
         soft_disable <= `SFPLC_SOFT_DIS_RST;
         o_sda_o <= 1'b0;
         o_sda_oe_n <= 1'b1;
      end else begin
         o_sda_o <= 1'b0; // Open drain only ever pulls low
         if (start_cond) begin
            state <= ST_ADDR;
            bitcnt <= `SFPLC_BITCNT_ZERO;
            o_sda_oe_n <= 1'b1;
         end else if (stop_cond) begin
            state <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            // Sampling edge
            case (state)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  shreg <= {shreg[6:0], i_sda};
                  bitcnt <= bitcnt + `SFPLC_BITCNT_ONE;
               end
               ST_RDATA: begin
                  shreg <= {shreg[6:0], 1'b0};
                  bitcnt <= bitcnt + `SFPLC_BITCNT_ONE;
               end
               ST_RACK: begin
                  master_ack <= ~i_sda;
               end
               default: begin
                  bitcnt <= bitcnt;
               end
            endcase
         end else if (scl_fall) begin
            // Driving edge
            case (state)
               ST_ADDR: begin
                  if (byte_done) begin
                     if (addr_match) begin
                        rw <= shreg[0];
                        o_sda_oe_n <= 1'b0;
                        state <= ST_ADDR_ACK;
                     end else begin
                        state <= ST_IDLE; // Other devices share the wire
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  bitcnt <= `SFPLC_BITCNT_ZERO;
                  if (rw) begin
                     shreg <= rd_byte;
                     o_sda_oe_n <= rd_byte[7];
                     ptr <= ptr + 8'h01;
                     state <= ST_RDATA;
                  end else begin
                     o_sda_oe_n <= 1'b1;
                     state <= ST_PTR;
                  end
               end
               ST_PTR: begin
                  if (byte_done) begin
                     ptr <= shreg;
                     o_sda_oe_n <= 1'b0;
                     state <= ST_PTR_ACK;
                  end
               end
               ST_PTR_ACK, ST_WDATA_ACK: begin
                  bitcnt <= `SFPLC_BITCNT_ZERO;
                  o_sda_oe_n <= 1'b1;
                  state <= ST_WDATA;
               end
               ST_WDATA: begin
                  if (byte_done) begin
                     // Only the software disable bit is writable
                     if (ptr == `SFPLC_REG_STATUS) begin
                        soft_disable <= shreg[`SFPLC_BIT_SOFT_DIS];
                     end
                     ptr <= ptr + 8'h01; // Wraps at the end of the space
                     o_sda_oe_n <= 1'b0;
                     state <= ST_WDATA_ACK;
                  end
               end
               ST_RDATA: begin
                  if (byte_done) begin
                     o_sda_oe_n <= 1'b1; // Let the master answer
                     state <= ST_RACK;
                  end else begin
                     o_sda_oe_n <= shreg[7];
                  end
               end
               ST_RACK: begin
                  bitcnt <= `SFPLC_BITCNT_ZERO;
                  if (master_ack) begin
                     shreg <= rd_byte;
                     o_sda_oe_n <= rd_byte[7];
                     ptr <= ptr + 8'h01;
                     state <= ST_RDATA;
                  end else begin
                     o_sda_oe_n <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  o_sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // sfplc_top
